// >>> pprt_device.sv
`timescale 1ns/1ps
// device end: power-on reset, image load, endpoint bring-up
module pprt_device
    import pprt_pkg::*;
    #(parameter logic [15:0] TICK_CYCLES = MS_CYCLES_W)
(
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic SUPPLY_OK_I,
    input wire logic POR_SPEED_SELECT_I,
    input wire logic PERIPHERY_MODE_I,
    input wire logic LINK_TRAINED_I,
    pprt_if.device LINK,
    output logic CORE_RESET_O,
    output logic ENDPOINT_RESET_O,
    output logic FUNCTION_ENABLE_O,
    output logic FABRIC_CONFIG_PATH_O,
    output logic CONFIG_LATE_O
);
    logic [15:0] cyc_reg;
    logic tick;
    logic [15:0] rel_cyc_reg;
    logic rel_tick;
    logic [7:0] pwr_ms_reg;
    logic [7:0] phase_ms_reg;
    logic [7:0] since_rst_reg;
    logic periphery_reg;
    logic cfg_done_reg;
    logic train_reg;
    logic active_reg;
    logic perst_n;
    pprt_dev_state_e state_reg;

    assign perst_n = LINK.fundamental_reset_in_n;

    // ----------------------------------------------------------------
    // millisecond tick
    // ----------------------------------------------------------------
    // prescaler to 1 ms
    assign tick = (cyc_reg == TICK_CYCLES - CYC_ONE);

    always_ff @(posedge CLK_I)
    begin
        if (RST_I || tick)
            cyc_reg <= CYC_ZERO;
        else
            cyc_reg <= cyc_reg + CYC_ONE;
    end

    always_ff @(posedge CLK_I)
    begin
        if (RST_I || !SUPPLY_OK_I)
            pwr_ms_reg <= MS_ZERO;
        else if (tick && pwr_ms_reg != WAKE_MAX_MS)
            pwr_ms_reg <= pwr_ms_reg + MS_ONE;
    end

    // prescaler restarted at release, so the minimum waits
    // never lose a partial ms to the host's tick phase
    assign rel_tick = (rel_cyc_reg == TICK_CYCLES - CYC_ONE);

    always_ff @(posedge CLK_I)
    begin
        if (RST_I || !perst_n || rel_tick)
            rel_cyc_reg <= CYC_ZERO;
        else
            rel_cyc_reg <= rel_cyc_reg + CYC_ONE;
    end

    always_ff @(posedge CLK_I)
    begin
        if (RST_I || !perst_n)
            since_rst_reg <= MS_ZERO;
        else if (rel_tick && since_rst_reg != WAKE_MAX_MS)
            since_rst_reg <= since_rst_reg + MS_ONE;
    end

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    // supply loss restarts everything from power-on reset
    always_ff @(posedge CLK_I)
    begin
        if (RST_I || !SUPPLY_OK_I)
        begin
            state_reg <= PPRT_POR;
            phase_ms_reg <= MS_ZERO;
            periphery_reg <= 1'b0;
        end
        else
        begin
            if (tick)
                phase_ms_reg <= phase_ms_reg + MS_ONE;
            unique case (state_reg)
                PPRT_POR:
                begin
                    // fast reset delay when select is high
                    if (tick && phase_ms_reg ==
                        (POR_SPEED_SELECT_I ? POR_FAST_MS : POR_SLOW_MS))
                    begin
                        state_reg <= PPRT_CONFIG;
                        phase_ms_reg <= MS_ZERO;
                        periphery_reg <= PERIPHERY_MODE_I; // mode caught at end of power-on reset
                    end
                end
                PPRT_CONFIG:
                begin
                    // load time bounded well below 120 ms
                    if (tick && phase_ms_reg ==
                        (periphery_reg ? PERI_CFG_MS : FULL_CFG_MS))
                    begin
                        state_reg <= PPRT_WAIT_RST;
                        phase_ms_reg <= MS_ZERO;
                    end
                end
                PPRT_WAIT_RST:
                begin
                    // reset release starts the endpoint machine
                    if (perst_n)
                        state_reg <= PPRT_WAIT_TRAIN;
                end
                PPRT_WAIT_TRAIN:
                begin
                    // hold off training 20 ms after release
                    if (!perst_n)
                        state_reg <= PPRT_WAIT_RST;
                    else if (since_rst_reg >= TRAIN_MIN_MS)
                        state_reg <= PPRT_TRAIN;
                end
                PPRT_TRAIN:
                begin
                    // active no sooner than 100 ms after release
                    if (!perst_n)
                        state_reg <= PPRT_WAIT_RST;
                    else if (LINK_TRAINED_I && since_rst_reg >= ACTIVE_MIN_MS)
                        state_reg <= PPRT_ACTIVE;
                end
                PPRT_ACTIVE:
                begin
                    if (!perst_n)
                        state_reg <= PPRT_WAIT_RST;
                end
                default:
                begin
                    state_reg <= PPRT_POR;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // done low while loading the fabric
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
            cfg_done_reg <= 1'b0;
        else
            cfg_done_reg <= (state_reg != PPRT_POR) && (state_reg != PPRT_CONFIG)
                && !(periphery_reg && state_reg != PPRT_ACTIVE);
    end

    // endpoint and transceivers follow fundamental reset
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            CORE_RESET_O <= 1'b1;
            ENDPOINT_RESET_O <= 1'b1;
        end
        else
        begin
            CORE_RESET_O <= (state_reg == PPRT_POR);
            ENDPOINT_RESET_O <= !perst_n || state_reg == PPRT_POR;
        end
    end

    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            train_reg <= 1'b0;
            active_reg <= 1'b0;
            CONFIG_LATE_O <= 1'b0;
        end
        else
        begin
            train_reg <= (state_reg == PPRT_TRAIN);
            active_reg <= (state_reg == PPRT_ACTIVE);
            if (!SUPPLY_OK_I)
                CONFIG_LATE_O <= 1'b0;
            else if ((state_reg == PPRT_POR || state_reg == PPRT_CONFIG)
                && pwr_ms_reg >= CONFIG_MAX_MS)
                CONFIG_LATE_O <= 1'b1;
        end
    end

    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            FUNCTION_ENABLE_O <= 1'b0;
            FABRIC_CONFIG_PATH_O <= 1'b0;
        end
        else
        begin
            FUNCTION_ENABLE_O <= (state_reg == PPRT_ACTIVE);
            FABRIC_CONFIG_PATH_O <= (state_reg == PPRT_ACTIVE) && periphery_reg;
        end
    end

    assign LINK.train_ready = train_reg;
    assign LINK.link_active = active_reg;
    assign LINK.fabric_config_done = cfg_done_reg;
endmodule

// >>> pprt_pkg.sv
// Overview of operation
// - host holds fundamental reset 100 ms minimum
// - 20 ms after release before training
// - 100 ms after release before link active
// - full image configured within 120 ms
// - periphery image configured within 120 ms
// - power-on to link active within 200 ms
// - speed select high gives 4-12 ms reset
// - logic held in reset until supplies good
// - reset release initialises device state machines
// - endpoint ready for training within 120 ms
// - function starts once link is active
// - low fundamental reset holds transceivers, endpoint
// - config done low during fabric configuration
package pprt_pkg;
    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 40_000_000;
    localparam int MS_CYCLES = CLK_HZ / 1000;
    localparam logic [15:0] MS_CYCLES_W = 16'(MS_CYCLES);
    localparam logic [7:0] PERST_MIN_MS = 8'h64;      // 100 ms
    localparam logic [7:0] TRAIN_MIN_MS = 8'h14;      // 20 ms
    localparam logic [7:0] ACTIVE_MIN_MS = 8'h64;     // 100 ms
    localparam logic [7:0] CONFIG_MAX_MS = 8'h78;     // 120 ms
    localparam logic [7:0] WAKE_MAX_MS = 8'hC8;       // 200 ms
    localparam logic [7:0] POR_FAST_MS = 8'h04;       // within 4..12 ms
    localparam logic [7:0] POR_SLOW_MS = 8'h0C;       // slow select bound
    localparam logic [7:0] FULL_CFG_MS = 8'h50;       // full image load time
    localparam logic [7:0] PERI_CFG_MS = 8'h0A;       // periphery load time
    localparam logic [7:0] MS_ZERO = 8'h00;
    localparam logic [7:0] MS_ONE = 8'h01;
    localparam logic [15:0] CYC_ZERO = 16'h0000;
    localparam logic [15:0] CYC_ONE = 16'h0001;

    typedef enum logic [2:0] {
        PPRT_POR = 3'b000,
        PPRT_CONFIG = 3'b001,
        PPRT_WAIT_RST = 3'b010,
        PPRT_WAIT_TRAIN = 3'b011,
        PPRT_TRAIN = 3'b100,
        PPRT_ACTIVE = 3'b101
    } pprt_dev_state_e;

    typedef enum logic [1:0] {
        PPRT_H_HOLD = 2'b00,
        PPRT_H_WAIT = 2'b01,
        PPRT_H_UP = 2'b10
    } pprt_host_state_e;
endpackage

// >>> pprt_if.sv
`timescale 1ns/1ps
// fundamental reset and link status between host and device
interface pprt_if;
    logic fundamental_reset_in_n;   // low holds the endpoint in reset
    logic train_ready;              // device endpoint may start training
    logic link_active;              // device link reached active state
    logic fabric_config_done;       // low while fabric loads

    modport host
    (
        output fundamental_reset_in_n,
        input train_ready,
        input link_active,
        input fabric_config_done
    );
    modport device
    (
        input fundamental_reset_in_n,
        output train_ready,
        output link_active,
        output fabric_config_done
    );
endinterface

// >>> pprt_host.sv
`timescale 1ns/1ps
// host end: holds fundamental reset after power and watches wake-up
module pprt_host
    import pprt_pkg::*;
    #(parameter logic [15:0] TICK_CYCLES = MS_CYCLES_W)
(
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic POWER_GOOD_I,
    pprt_if.host LINK,
    output logic RESET_RELEASED_O,
    output logic LINK_UP_O,
    output logic WAKE_TIMEOUT_O
);
    logic [15:0] cyc_reg;
    logic tick;
    logic [7:0] hold_reg;
    logic [7:0] wake_reg;
    logic perst_n_reg;
    pprt_host_state_e state_reg;

    // ----------------------------------------------------------------
    // millisecond tick
    // ----------------------------------------------------------------
    assign tick = (cyc_reg == TICK_CYCLES - CYC_ONE);

    // free-running prescaler
    always_ff @(posedge CLK_I)
    begin
        if (RST_I || tick)
            cyc_reg <= CYC_ZERO;
        else
            cyc_reg <= cyc_reg + CYC_ONE;
    end

    // ----------------------------------------------------------------
    // reset sequencing
    // ----------------------------------------------------------------
    // minimum reset hold
    always_ff @(posedge CLK_I)
    begin
        if (RST_I || !POWER_GOOD_I)
        begin
            state_reg <= PPRT_H_HOLD;
            hold_reg <= MS_ZERO;
            perst_n_reg <= 1'b0;
        end
        else
        begin
            unique case (state_reg)
                PPRT_H_HOLD:
                begin
                    // one extra tick so a partial first ms never shortens it
                    if (tick)
                        hold_reg <= hold_reg + MS_ONE;
                    if (tick && hold_reg == PERST_MIN_MS)
                    begin
                        perst_n_reg <= 1'b1;
                        state_reg <= PPRT_H_WAIT;
                    end
                end
                PPRT_H_WAIT:
                begin
                    if (LINK.link_active)
                        state_reg <= PPRT_H_UP;
                end
                PPRT_H_UP:
                begin
                    state_reg <= PPRT_H_UP;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_I)
    begin
        if (RST_I || !POWER_GOOD_I)
        begin
            wake_reg <= MS_ZERO;
            WAKE_TIMEOUT_O <= 1'b0;
        end
        else if (state_reg != PPRT_H_UP && tick)
        begin
            // the first partial ms is counted, so wait one tick past the budget;
            // the 100 ms hold plus 100 ms to active fills the budget exactly
            if (wake_reg > WAKE_MAX_MS)
                WAKE_TIMEOUT_O <= 1'b1;
            else
                wake_reg <= wake_reg + MS_ONE;
        end
    end

    assign LINK.fundamental_reset_in_n = perst_n_reg;

    // status outputs
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            RESET_RELEASED_O <= 1'b0;
            LINK_UP_O <= 1'b0;
        end
        else
        begin
            RESET_RELEASED_O <= perst_n_reg;
            LINK_UP_O <= (state_reg == PPRT_H_UP);
        end
    end
endmodule

// >>> pprt_checker.sv
`timescale 1ns/1ps
// watches the reset and link status wires between host and device
module pprt_checker
    import pprt_pkg::*;
    #(parameter logic [15:0] TICK_CYCLES = MS_CYCLES_W)
(
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic fundamental_reset_in_n,
    input wire logic train_ready,
    input wire logic link_active,
    input wire logic fabric_config_done
);
    localparam int MS_LEN = int'(TICK_CYCLES);
    localparam int HOLD_MIN = 100 * MS_LEN;
    localparam int TRAIN_MIN = 20 * MS_LEN;
    localparam int ACT_MIN = 100 * MS_LEN;
    localparam int TRAIN_LATE = 21 * MS_LEN + 8;
    logic [31:0] hi_cnt_reg;
    logic [31:0] lo_cnt_reg;
    default clocking @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // cycles spent released; small slack covers the register stage
    always_ff @(posedge CLK_I)
    begin
        if (RST_I || !fundamental_reset_in_n)
            hi_cnt_reg <= '0;
        else
            hi_cnt_reg <= hi_cnt_reg + 1;
    end
    // cycles spent held in reset
    always_ff @(posedge CLK_I)
    begin
        if (RST_I || fundamental_reset_in_n)
            lo_cnt_reg <= '0;
        else
            lo_cnt_reg <= lo_cnt_reg + 1;
    end
    sequence s_release;
        $rose(fundamental_reset_in_n);
    endsequence
    sequence s_active;
        $rose(link_active);
    endsequence
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    a_release_min_hold: assert property (s_release |-> lo_cnt_reg >= HOLD_MIN - 2)
        else $error("reset released too soon");
    a_train_min_wait: assert property ($rose(train_ready) |-> hi_cnt_reg >= TRAIN_MIN - 2)
        else $error("training began too soon");
    a_release_quiet: assert property (s_release |-> (!train_ready && !link_active) [*8])
        else $error("link status up at release");
    a_active_min_wait: assert property (s_active |-> hi_cnt_reg >= ACT_MIN - 2)
        else $error("link active too soon");
    a_train_late_bound: assert property (
        (fundamental_reset_in_n && hi_cnt_reg == TRAIN_LATE) |-> (train_ready || link_active))
        else $error("training not started in time");
    a_train_then_active: assert property (s_active |-> $past(train_ready))
        else $error("active without training");
    a_reset_clears_link: assert property (
        !fundamental_reset_in_n |-> ##2 (!train_ready && !link_active))
        else $error("link status kept under reset");
    a_done_at_active: assert property (s_active |-> ##[0:2] fabric_config_done)
        else $error("config done low while active");
endmodule

// >>> tb_pcie_powerup_reset_timing.sv
`timescale 1ns/1ps
module tb_pcie_powerup_reset_timing
    import pprt_pkg::*;
;
    logic clk, rst, pgood, supply, fast, peri, trained;
    logic rel_o, up_o, wto_o, core_o, ep_o, fn_o, path_o, late_o;
    logic [15:0] lfsr;
    int bad_count;
    int checks;
    // a short ms keeps the run small; every interval is counted in whole ms
    localparam logic [15:0] TB_TICK = 16'h0028;
    localparam int TB_MS = int'(TB_TICK);
    pprt_if u_pprt_if ();
    pprt_host #(.TICK_CYCLES(TB_TICK)) u_pprt_host (.CLK_I(clk), .RST_I(rst), .POWER_GOOD_I(pgood),
        .LINK(u_pprt_if.host), .RESET_RELEASED_O(rel_o), .LINK_UP_O(up_o),
        .WAKE_TIMEOUT_O(wto_o));
    pprt_device #(.TICK_CYCLES(TB_TICK)) u_pprt_device (.CLK_I(clk), .RST_I(rst),
        .SUPPLY_OK_I(supply),
        .POR_SPEED_SELECT_I(fast), .PERIPHERY_MODE_I(peri), .LINK_TRAINED_I(trained),
        .LINK(u_pprt_if.device), .CORE_RESET_O(core_o), .ENDPOINT_RESET_O(ep_o),
        .FUNCTION_ENABLE_O(fn_o), .FABRIC_CONFIG_PATH_O(path_o), .CONFIG_LATE_O(late_o));
    pprt_checker #(.TICK_CYCLES(TB_TICK)) u_pprt_checker (.CLK_I(clk), .RST_I(rst),
        .fundamental_reset_in_n(u_pprt_if.fundamental_reset_in_n),
        .train_ready(u_pprt_if.train_ready), .link_active(u_pprt_if.link_active),
        .fabric_config_done(u_pprt_if.fabric_config_done));
    // 40 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    // expected end of the power-on delay in ms
    function automatic int por_ms(input logic f);
        return f ? 4 : 12;
    endfunction
    task chk(input logic ok, input string msg);
        checks++;
        if (ok !== 1'b1)
        begin
            bad_count++;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask
    task final_report;
        if (bad_count == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // one power-up to link active; trained follows ready after a random delay
    task boot(input logic f, input logic pm);
        int cyc, t_core, t_rel, t_trn, t_done, t_act, trig, pms;
        t_core = -1;
        t_rel = -1;
        t_trn = -1;
        t_done = -1;
        t_act = -1;
        trig = -1;
        pms = por_ms(f) * TB_MS;
        @(posedge clk);
        fast <= f;
        peri <= pm;
        supply <= 1'b1;
        pgood <= 1'b1;
        lfsr = lfsr_next(lfsr);
        for (cyc = 0; t_act < 0; cyc++)
        begin
            @(posedge clk);
            if (cyc == trig)
                trained <= 1'b1;
            #1;
            if (t_core < 0 && core_o === 1'b0) t_core = cyc;
            if (t_rel < 0 && u_pprt_if.fundamental_reset_in_n === 1'b1) t_rel = cyc;
            if (t_done < 0 && u_pprt_if.fabric_config_done === 1'b1) t_done = cyc;
            if (t_act < 0 && u_pprt_if.link_active === 1'b1) t_act = cyc;
            if (t_trn < 0 && u_pprt_if.train_ready === 1'b1)
            begin
                t_trn = cyc;
                // one cycle on, so a zero delay is never missed
                trig = cyc + 1 + int'(lfsr[7:0]);
            end
            if (t_rel < 0) chk(ep_o === 1'b1, "endpoint out of reset early");
            if (cyc > 250 * TB_MS)
            begin
                $display("Error at %0t: link never came up", $time);
                bad_count++;
                final_report();
            end
        end
        repeat (3) @(posedge clk);
        #1;
        chk(t_core >= pms - 2 && t_core <= pms + TB_MS + 4, "power-on delay");
        chk(t_rel >= 100 * TB_MS && rel_o === 1'b1, "reset released early");
        chk(t_trn - t_rel >= 20 * TB_MS && t_trn - t_rel <= 21 * TB_MS + 4, "train start");
        chk(t_act - t_rel >= 100 * TB_MS, "link active early");
        // hold and active minima fill the budget, so one partial ms is allowed
        chk(t_act - t_rel <= 100 * TB_MS + 4 && t_act <= 201 * TB_MS + 4, "wake budget");
        chk(up_o === 1'b1 && wto_o === 1'b0, "host link view");
        if (pm) chk(t_done >= t_act && late_o === 1'b0, "periphery load");
        else chk(t_done >= 0 && t_done <= 120 * TB_MS && late_o === 1'b0, "image load");
        chk(fn_o === 1'b1 && ep_o === 1'b0 && core_o === 1'b0 && path_o === pm, "start");
        // supply loss must pull everything back into reset
        @(posedge clk);
        pgood <= 1'b0;
        supply <= 1'b0;
        trained <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        chk(core_o === 1'b1 && ep_o === 1'b1 && fn_o === 1'b0, "supply loss");
        chk(u_pprt_if.link_active === 1'b0 && rel_o === 1'b0, "link after loss");
    endtask
    // link never trains: the host watchdog fires, and not before 200 ms
    task no_link;
        int cyc;
        @(posedge clk);
        supply <= 1'b1;
        pgood <= 1'b1;
        for (cyc = 0; wto_o !== 1'b1; cyc++)
        begin
            @(posedge clk);
            #1;
            if (cyc > 205 * TB_MS)
            begin
                $display("Error at %0t: watchdog never fired", $time);
                bad_count++;
                final_report();
            end
        end
        chk(cyc >= 200 * TB_MS && up_o === 1'b0, "watchdog early");
        chk(u_pprt_if.train_ready === 1'b1 && u_pprt_if.link_active === 1'b0, "no train");
        chk(u_pprt_if.fabric_config_done === 1'b0 || !peri, "fabric done early");
        @(posedge clk);
        pgood <= 1'b0;
        supply <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        chk(wto_o === 1'b0 && ep_o === 1'b1, "watchdog clear");
    endtask
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        rst = 1'b1;
        pgood = 1'b0;
        supply = 1'b0;
        fast = 1'b0;
        peri = 1'b0;
        trained = 1'b0;
        lfsr = 16'h001F;
        bad_count = 0;
        checks = 0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        chk(u_pprt_if.fundamental_reset_in_n === 1'b0 && core_o === 1'b1, "reset state");
        boot(1'b1, 1'b0);
        boot(lfsr[0], 1'b1);
        no_link();
        final_report();
    end
endmodule
